// ---- design/ccto_pkg.sv ----
// Behaviour
// - fast charge limit is two to the twenty-two oscillator periods
// - trickle limit is one eighth of the fast charge limit
// - timeout gate low disables the fast charge timeout entirely
// - trickle timeout is enforced whatever the timeout gate level
// - enable with low battery enters trickle; each trickle entry clears the timer
// - timeout active and limit elapsed stops charging and asserts fault
// - battery above trickle threshold in time moves to fast, timer cleared
// - fast charge without end of charge before limit raises timeout fault
// - end of charge enters complete, releases status, keeps charging
// - supply above power-on threshold resets state and timer first
// - after reset stay disabled until enable becomes active
// - timeout fault leaves only by enable toggle or power cycle
// - in complete, recharge condition drives status low again
// - disabling shuts down oscillator and timer
// - below trickle threshold the charger selects one tenth current; here only on entry from disabled, not on a drop in fast
// - recharge condition comes from the external recharge comparator
// - end of charge and recharge status changes delayed 0.5 to 1.5 periods
// - temperature out of window pauses charger and timer, asserts fault
package ccto_pkg;

  // register byte offsets
  localparam logic [7:0] STATE_OFS = 8'h00;
  localparam logic [7:0] TIMER_OFS = 8'h04;
  localparam logic [7:0] OSC_OFS = 8'h08;

  // status word field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_STATUS_BIT = 4;
  localparam int ST_CHARGE_BIT = 5;
  localparam int ST_TRICKLE_BIT = 6;
  localparam int ST_RECHARGE_BIT = 7;
  localparam int ST_PINS_LSB = 8;

  // synchronised input bit positions
  localparam int PIN_EN = 0;
  localparam int PIN_GATE = 1;
  localparam int PIN_BAT = 2;
  localparam int PIN_EOC = 3;
  localparam int PIN_RCH = 4;
  localparam int PIN_TEMP = 5;
  localparam int PIN_SUPPLY = 6;
  localparam int PIN_NUM = 7;

  // timer and oscillator
  localparam int TIMER_W = 22;
  localparam int TRICKLE_SHIFT = 3;
  localparam logic [TIMER_W-1:0] TRICKLE_LIMIT =
    TIMER_W'(1) << (TIMER_W - TRICKLE_SHIFT);
  localparam int OSC_W = 24;
  localparam int OSC_MIN_CYC = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int OSC_PERIOD_NS = 3000000;
  localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // charge cycle states, gray along the usual path
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DISABLED = 3'h1,
    ST_TRICKLE = 3'h3,
    ST_FAST = 3'h2,
    ST_COMPLETE = 3'h6,
    ST_FAULT = 3'h7
  } ccto_state_type;

endpackage : ccto_pkg

// ---- design/ccto_top.sv ----
`timescale 1ns/100ps
module ccto_top #(
  parameter int OSC_PERIOD_CYC = ccto_pkg::OSC_PERIOD_CYC
) (
  input wire logic i_mclk, // 50 MHz clock
  input wire logic i_rst_b, // async reset, active low
  input wire logic i_enable, // charger enable pin
  input wire logic i_timeout_gate_input, // low disables fast timeout
  input wire logic i_bat_above_trickle, // battery above 2.8 V
  input wire logic i_eoc, // end-of-charge comparator
  input wire logic i_recharge, // battery below recharge level
  input wire logic i_temp_ok, // temperature inside window
  input wire logic i_supply_ok, // supply above power-on threshold
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error
  output logic o_fault_oe, // pull fault pin low
  output logic o_status_oe, // pull status pin low
  output logic o_charge_en, // pass element on
  output logic o_trickle_sel // one tenth current select
);

  typedef struct packed {
    logic [ccto_pkg::PIN_NUM-1:0] s1;
    logic [ccto_pkg::PIN_NUM-1:0] s2;
    logic [ccto_pkg::PIN_NUM-1:0] s3;
    logic [ccto_pkg::PIN_NUM-1:0] flt;
    ccto_pkg::ccto_state_type state;
    logic [ccto_pkg::OSC_W-1:0] div;
    logic [ccto_pkg::OSC_W-1:0] osc_period;
    logic [ccto_pkg::TIMER_W-1:0] timer;
    logic pend_eoc;
    logic pend_rch;
    logic recharge;
    logic fault_drv;
    logic status_drv;
    logic charge_en;
    logic trickle_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ccto_reg_type;

  localparam ccto_reg_type REG_RST = '{
    state: ccto_pkg::ST_OFF,
    osc_period: ccto_pkg::OSC_W'(OSC_PERIOD_CYC),
    default: '0
  };

  // refuse oscillator periods the divider cannot count
  if (OSC_PERIOD_CYC < ccto_pkg::OSC_MIN_CYC ||
      OSC_PERIOD_CYC >= (1 << ccto_pkg::OSC_W)) begin : g_chk
    $error("oscillator period out of range");
  end

  logic [1:0] rst_sync_r;
  logic rst_b;
  ccto_reg_type r;
  ccto_reg_type r_nxt;

  // reset release through two flops
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  logic [ccto_pkg::PIN_NUM-1:0] agree;
  logic run;
  logic tick;
  logic half;
  logic paused;
  logic fast_hit;
  logic trickle_hit;
  logic eoc_ok;
  logic rch_ok;
  logic acc;
  logic addr_ok;
  logic [31:0] rd_word;

  // next state of the whole block
  always_comb begin
    r_nxt = r;

    // pin synchronisers, change taken once stages two and three agree
    r_nxt.s1 = {i_supply_ok, i_temp_ok, i_recharge, i_eoc,
                i_bat_above_trickle, i_timeout_gate_input, i_enable};
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    agree = ~(r.s2 ^ r.s3);
    r_nxt.flt = (agree & r.s3) | (~agree & r.flt);

    // oscillator divider, stopped while off or disabled
    run = (r.state != ccto_pkg::ST_OFF) &&
          (r.state != ccto_pkg::ST_DISABLED);
    tick = run && (r.div == r.osc_period - ccto_pkg::OSC_W'(1));
    half = run && (r.div == (r.osc_period >> 1));
    if (!run || tick) begin
      r_nxt.div = '0;
    end else begin
      r_nxt.div = r.div + ccto_pkg::OSC_W'(1);
    end

    // temperature window pauses timer and charger
    paused = !r.flt[ccto_pkg::PIN_TEMP];

    // elapsed charge time in oscillator ticks
    if (tick && !paused && (r.state == ccto_pkg::ST_TRICKLE ||
                            r.state == ccto_pkg::ST_FAST)) begin
      r_nxt.timer = r.timer + ccto_pkg::TIMER_W'(1);
    end
    // fast limit at wrap, counted only with the gate high
    fast_hit = tick && !paused && (&r.timer) &&
               r.flt[ccto_pkg::PIN_GATE];
    // trickle limit at one eighth, gate ignored
    trickle_hit = (r.timer == ccto_pkg::TRICKLE_LIMIT);

    // status filter: seen at mid period, confirmed at the tick
    if (half) begin
      r_nxt.pend_eoc = r.flt[ccto_pkg::PIN_EOC];
      r_nxt.pend_rch = r.flt[ccto_pkg::PIN_RCH];
    end
    eoc_ok = tick && r.pend_eoc && r.flt[ccto_pkg::PIN_EOC];
    rch_ok = tick && r.pend_rch && r.flt[ccto_pkg::PIN_RCH];

    // charge cycle state machine
    if (!r.flt[ccto_pkg::PIN_SUPPLY]) begin
      r_nxt.state = ccto_pkg::ST_OFF;
      r_nxt.timer = '0;
      r_nxt.recharge = 1'b0;
    end else begin
      unique case (r.state)
        ccto_pkg::ST_OFF: begin
          // supply up: clear state and timer first
          r_nxt.state = ccto_pkg::ST_DISABLED;
          r_nxt.timer = '0;
          r_nxt.recharge = 1'b0;
        end
        ccto_pkg::ST_DISABLED: begin
          r_nxt.timer = '0;
          r_nxt.pend_eoc = 1'b0;
          r_nxt.pend_rch = 1'b0;
          if (r.flt[ccto_pkg::PIN_EN]) begin
            if (r.flt[ccto_pkg::PIN_BAT]) begin
              r_nxt.state = ccto_pkg::ST_FAST;
            end else begin
              r_nxt.state = ccto_pkg::ST_TRICKLE;
            end
          end
        end
        ccto_pkg::ST_TRICKLE: begin
          if (!r.flt[ccto_pkg::PIN_EN]) begin
            r_nxt.state = ccto_pkg::ST_DISABLED;
            r_nxt.timer = '0;
          end else if (trickle_hit) begin
            r_nxt.state = ccto_pkg::ST_FAULT;
          end else if (r.flt[ccto_pkg::PIN_BAT] && !paused) begin
            r_nxt.state = ccto_pkg::ST_FAST;
            r_nxt.timer = '0;
          end
        end
        ccto_pkg::ST_FAST: begin
          if (!r.flt[ccto_pkg::PIN_EN]) begin
            r_nxt.state = ccto_pkg::ST_DISABLED;
            r_nxt.timer = '0;
          end else if (fast_hit) begin
            r_nxt.state = ccto_pkg::ST_FAULT;
          end else if (eoc_ok && !paused) begin
            r_nxt.state = ccto_pkg::ST_COMPLETE;
            r_nxt.recharge = 1'b0;
          end
        end
        ccto_pkg::ST_COMPLETE: begin
          if (!r.flt[ccto_pkg::PIN_EN]) begin
            r_nxt.state = ccto_pkg::ST_DISABLED;
            r_nxt.timer = '0;
            r_nxt.recharge = 1'b0;
          end else if (!r.recharge && rch_ok) begin
            r_nxt.recharge = 1'b1;
          end else if (r.recharge && eoc_ok) begin
            r_nxt.recharge = 1'b0;
          end
        end
        ccto_pkg::ST_FAULT: begin
          // only enable low or supply loss leaves the fault
          if (!r.flt[ccto_pkg::PIN_EN]) begin
            r_nxt.state = ccto_pkg::ST_DISABLED;
            r_nxt.timer = '0;
          end
        end
        default: begin
          r_nxt.state = ccto_pkg::ST_OFF;
        end
      endcase
    end

    // pin drives follow the next state
    r_nxt.charge_en = !paused && (r_nxt.state == ccto_pkg::ST_TRICKLE ||
                                  r_nxt.state == ccto_pkg::ST_FAST ||
                                  r_nxt.state == ccto_pkg::ST_COMPLETE);
    r_nxt.trickle_sel = (r_nxt.state == ccto_pkg::ST_TRICKLE);
    r_nxt.fault_drv = (r_nxt.state == ccto_pkg::ST_FAULT) ||
                      (paused && r_nxt.charge_en == 1'b0 &&
                       r_nxt.state != ccto_pkg::ST_OFF &&
                       r_nxt.state != ccto_pkg::ST_DISABLED);
    r_nxt.status_drv = (r_nxt.state == ccto_pkg::ST_TRICKLE) ||
                       (r_nxt.state == ccto_pkg::ST_FAST) ||
                       (r_nxt.state == ccto_pkg::ST_COMPLETE &&
                        r_nxt.recharge);

    // apb read word selection
    addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr == ccto_pkg::STATE_OFS ||
                                          i_paddr == ccto_pkg::TIMER_OFS ||
                                          i_paddr == ccto_pkg::OSC_OFS);
    rd_word = 32'h0;
    if (i_paddr == ccto_pkg::STATE_OFS) begin
      rd_word[ccto_pkg::ST_STATE_LSB +: 3] = r.state;
      rd_word[ccto_pkg::ST_FAULT_BIT] = r.fault_drv;
      rd_word[ccto_pkg::ST_STATUS_BIT] = r.status_drv;
      rd_word[ccto_pkg::ST_CHARGE_BIT] = r.charge_en;
      rd_word[ccto_pkg::ST_TRICKLE_BIT] = r.trickle_sel;
      rd_word[ccto_pkg::ST_RECHARGE_BIT] = r.recharge;
      rd_word[ccto_pkg::ST_PINS_LSB +: ccto_pkg::PIN_NUM] = r.flt;
    end else if (i_paddr == ccto_pkg::TIMER_OFS) begin
      rd_word[ccto_pkg::TIMER_W-1:0] = r.timer;
    end else if (i_paddr == ccto_pkg::OSC_OFS) begin
      rd_word[ccto_pkg::OSC_W-1:0] = r.osc_period;
    end

    // apb slave, one wait state per access
    acc = i_psel && i_penable;
    r_nxt.pready = acc && !r.pready;
    if (acc && !r.pready) begin
      r_nxt.prdata = i_pwrite ? 32'h0 : rd_word;
      r_nxt.pslverr = !addr_ok ||
                      (i_pwrite && i_paddr == ccto_pkg::OSC_OFS &&
                       (i_pwdata[31:ccto_pkg::OSC_W] != '0 ||
                        i_pwdata[ccto_pkg::OSC_W-1:0] <
                        ccto_pkg::OSC_W'(ccto_pkg::OSC_MIN_CYC)));
    end else begin
      // answer stands only in the ready cycle, zero again after it
      r_nxt.pslverr = 1'b0;
      r_nxt.prdata = 32'h0;
    end
    // write takes effect at the ready edge
    if (acc && r.pready && !r.pslverr && i_pwrite &&
        i_paddr == ccto_pkg::OSC_OFS) begin
      r_nxt.osc_period = i_pwdata[ccto_pkg::OSC_W-1:0];
      r_nxt.div = '0;
    end
  end

  // state register
  always_ff @(posedge i_mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= REG_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // outputs straight from flops
  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_fault_oe = r.fault_drv;
  assign o_status_oe = r.status_drv;
  assign o_charge_en = r.charge_en;
  assign o_trickle_sel = r.trickle_sel;

endmodule : ccto_top

// ---- verification/ccto_sva.sv ----
`timescale 1ns/100ps
module ccto_sva #(
  parameter int OSC_PERIOD_CYC = 4
) (
  input wire logic i_mclk, // clock
  input wire logic i_rst_b, // reset, active low
  input wire logic i_enable, // enable pin
  input wire logic i_temp_ok, // temperature window
  input wire logic i_supply_ok, // supply good
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic [7:0] i_paddr, // apb address
  input wire logic [31:0] o_prdata, // read data
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic o_fault_oe, // fault pin
  input wire logic o_status_oe, // status pin
  input wire logic o_charge_en, // pass element
  input wire logic o_trickle_sel // trickle current
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // access phase still waiting for its answer
  sequence s_taken;
    i_psel && i_penable && !o_pready;
  endsequence
  // charge, status and fault outputs released
  sequence s_quiet;
    !o_charge_en && !o_status_oe && !o_fault_oe;
  endsequence
  a_reset_quiet: assert property ($rose(i_rst_b) |-> s_quiet [*2])
    else $error("outputs active right after reset");
  a_pready_answer: assert property (s_taken |=> o_pready)
    else $error("no answer one cycle after access");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside ready cycle");
  a_bad_addr: assert property (o_pready && (i_paddr > 8'h08 ||
    i_paddr[1:0] != 2'h0) |-> o_pslverr)
    else $error("bad address not refused");
  a_trickle_power: assert property (o_trickle_sel |-> o_charge_en || o_fault_oe)
    else $error("trickle selected without charge or pause");
  a_disable_off: assert property (!i_enable [*8] |-> s_quiet)
    else $error("outputs active while disabled");
  a_supply_off: assert property (!i_supply_ok [*8] |-> s_quiet)
    else $error("outputs active with supply off");
  a_temp_pause: assert property (!i_temp_ok [*8] |-> !o_charge_en)
    else $error("charging while temperature bad");
endmodule : ccto_sva

// ---- verification/ccto_host.sv ----
`timescale 1ns/100ps
module ccto_host (
  input wire logic i_mclk, // clock
  input wire logic i_en_req, // wanted enable level
  input wire logic i_gate_req, // wanted gate level
  output logic o_enable, // enable pin
  output logic o_gate // timeout gate pin
);
  // host pins change just after an edge; a restart is an enable toggle
  always_ff @(posedge i_mclk) begin
    o_enable <= i_en_req;
    o_gate <= i_gate_req;
  end
endmodule : ccto_host

// ---- verification/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic clk, rst_b, en_r, gate_r, en, gate, bat, eoc, rch, temp, sup;
  logic psel, pen, pwr, rdy, err, f_oe, s_oe, chg, trk;
  logic [7:0] paddr;
  logic [31:0] pwd, prd;
  logic [17:0] q[$];
  logic [17:0] nt;
  int failures, n_tests, seed, per, w;
  ccto_top #(.OSC_PERIOD_CYC(4)) u_ccto_top (.i_mclk(clk), .i_rst_b(rst_b),
    .i_enable(en), .i_timeout_gate_input(gate), .i_bat_above_trickle(bat),
    .i_eoc(eoc), .i_recharge(rch), .i_temp_ok(temp), .i_supply_ok(sup),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .o_fault_oe(f_oe), .o_status_oe(s_oe), .o_charge_en(chg),
    .o_trickle_sel(trk));
  ccto_host u_ccto_host (.i_mclk(clk), .i_en_req(en_r), .i_gate_req(gate_r),
    .o_enable(en), .o_gate(gate));
  // clock of 20 ns
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // apb transfer; the expected result is noted first
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [7:0] m, input logic [7:0] e, input logic er);
    begin
      q.push_back({a == 8'h00 && !wr, m, e, er});
      psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwd <= d;
      @(posedge clk);
      pen <= 1;
      // wait until ready is seen high; if ready never comes only the watchdog ends this wait
      do begin
        @(posedge clk);
      end while (rdy !== 1'b1);
      psel <= 0;
      pen <= 0;
      // idle edge so the next setup never meets this release
      @(posedge clk);
    end
  endtask : apb
  task chk(input logic [31:0] rd, input logic er, input logic [17:0] t);
    begin
      n_tests++;
      if (((rd[7:0] ^ t[8:1]) & t[16:9]) !== 8'h00 || er !== t[0]) begin
        failures++;
        $display("Error %0t: got %h/%b want %h/%b", $time, rd, er, t[8:1], t[0]);
      end
    end
  endtask : chk
  // pin drives against the expected status bits
  task chk_pins(input logic [3:0] p, input logic [7:0] e);
    begin
      n_tests++;
      if (p !== e[6:3]) begin
        failures++;
        $display("Error %0t: pins %b want %b", $time, p, e[6:3]);
      end
    end
  endtask : chk_pins
  // results appear with ready; the oldest note is taken off
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      nt = q.pop_front();
      chk(prd, err, nt);
      if (nt[17]) chk_pins({trk, chg, s_oe, f_oe}, nt[8:1]);
    end
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task done(input string s);
    $display("test %0s done", s);
  endtask : done
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    wt(20000);
    failures++;
    finish_test;
  end
  initial begin
    seed = 69;
    {rst_b, en_r, bat, eoc, rch, psel, pen, pwr} = 0;
    {paddr, pwd, failures, n_tests} = 0;
    temp = 1;
    sup = 1;
    gate_r = 1;
    per = 4 + ($unsigned($random(seed)) % 8);
    w = 4 * per + 12;
    wt(12);
    rst_b <= 1;
    wt(10);
    apb(0, 8'h00, 0, 8'hFF, 8'h01, 0);
    apb(0, 8'h04, 0, 8'hFF, 8'h00, 0);
    apb(0, 8'h0C, 0, 8'hFF, 8'h00, 1);
    apb(0, 8'h02, 0, 8'hFF, 8'h00, 1);
    apb(1, 8'h08, 1, 8'h00, 8'h00, 1);
    apb(1, 8'h08, per, 8'h00, 8'h00, 0);
    apb(0, 8'h08, 0, 8'hFF, per[7:0], 0);
    done("registers");
    en_r <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h73, 0);
    bat <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h32, 0);
    gate_r <= 1'($random(seed));
    temp <= 0;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h1A, 0);
    temp <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h32, 0);
    done("charge");
    eoc <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h26, 0);
    eoc <= 0;
    rch <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'hB6, 0);
    rch <= 0;
    done("complete");
    sup <= 0;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h00, 0);
    sup <= 1;
    bat <= 0;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h73, 0);
    en_r <= 0;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h01, 0);
    apb(0, 8'h04, 0, 8'hFF, 8'h00, 0);
    bat <= 1;
    en_r <= 1;
    wt(w);
    apb(0, 8'h00, 0, 8'hFF, 8'h32, 0);
    done("power");
    wt(4);
    finish_test;
  end
endmodule : tb
bind ccto_top ccto_sva #(.OSC_PERIOD_CYC(OSC_PERIOD_CYC)) u_ccto_sva (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_enable(i_enable),
  .i_temp_ok(i_temp_ok), .i_supply_ok(i_supply_ok), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_fault_oe(o_fault_oe),
  .o_status_oe(o_status_oe), .o_charge_en(o_charge_en),
  .o_trickle_sel(o_trickle_sel));
